// File: bench/dioc_bench.sv
// self-checking bench for the dedicated i/o block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t got %0h exp %0h", $time, g, e); end end
module dioc_bench import dioc_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic want = 1'b0, go = 1'b0, stp = 1'b0;
    logic [1:0] key = KEY_TEACH;
    logic [3:0] run = 4'h0, pause = 4'h0, seen, launch, halt;
    logic [7:0] aw = 8'h00, ar = 8'h00, num = 8'h00, got, pnum;
    logic [31:0] wd = 32'h0, rdata;
    logic [15:0] pin, pout, pen;
    logic [1:0] bresp, rresp;
    logic awr, wr_rdy, bv, arr, rv, load;
    int err_count = 0, tests_run = 0, n_l = 0;
    logic [31:0] mp [8] = '{32'h04FF, 32'h01FF, 32'h02FF, 32'h05FF,
        32'h0305, 32'h0003, 32'h0700, 32'h06FF};
    always #2.5 clk = ~clk;
    dioc_plc plc (.clk(clk), .remote(pout[1]), .want(want), .go(go),
        .stop(stp), .num(num), .pio(pin));
    dioc_top dut (.SYS_CLK(clk), .SYS_RST(rst), .PIO_IN(pin),
        .KEY_MODE(key), .SLOT_RUN(run), .SLOT_PAUSE(pause),
        .PIO_OUT(pout), .PIO_OUT_EN(pen), .SLOT_LAUNCH(launch),
        .SLOT_HALT(halt), .PROG_LOAD(load), .PROG_NUM(pnum),
        .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1));
    // launch pulses stand one cycle, caught mid-cycle
    always @(negedge clk) begin
        if (|launch) begin
            seen = seen | launch;
            n_l++;
        end
        if (load) got = pnum;
    end
    // ------------------------------------------------------------------
    // bus and pin tasks
    // ------------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        forever begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
            if (bv) break;
        end
        `CHK(bresp, er)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        ar <= a;
        arv <= 1'b1;
        forever begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        `CHK(rdata, e)
        `CHK(rresp, er)
    endtask : rd
    task automatic pulse();
        seen = 4'h0;
        n_l = 0;
        go <= 1'b1;
        step(8);
        go <= 1'b0;
        step(8);
    endtask : pulse
    task give_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // hang guard, far beyond the few hundred cycles used
    initial begin
        #50000;
        err_count++;
        give_verdict();
    end
    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        step(2);
        rst <= 1'b0;
        step(1);
        rd(8'h00, 32'h0, RESP_OK);
        rd(8'h20, 32'h0305, RESP_OK);
        rd(8'h24, 32'h0003, RESP_OK);
        rd(8'h10, 32'hFFFF, RESP_OK);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h08, 32'h1, RESP_SLVERR);
        `CHK(pen, 16'h0009)
        foreach (mp[i]) wr(8'h10 + 8'(4 * i), mp[i], RESP_OK);
        wr(8'h00, 32'h1, RESP_OK);
        step(8);
        `CHK(pen, 16'h00FF)
        for (int k = 0; k < 3; k++) begin
            key <= 2'(k);
            step(8);
            `CHK(pout[5:1], {k == 1, 1'b1, 1'b0, k == 0, k == 2})
        end
        want <= 1'b1;
        step(8);
        `CHK(pout[3], 1'b1)
        rd(8'h08, 32'h2013, RESP_OK);
        wr(8'h00, 32'h11, RESP_OK);
        step(8);
        `CHK(pout[3], 1'b0)
        wr(8'h00, 32'h01, RESP_OK);
        step(8);
        pulse();
        `CHK(n_l, 1)
        `CHK(seen, 4'b0001)
        run <= 4'h1;
        step(4);
        `CHK(pout[0], 1'b1)
        run <= 4'h0;
        pause <= 4'h1;
        step(4);
        `CHK({pout[7], pout[0]}, 2'b10)
        run <= 4'h1;
        step(4);
        `CHK(pout[7], 1'b0)
        run <= 4'h0;
        wr(8'h04, 32'h24, RESP_OK);
        wr(8'h00, 32'h0B, RESP_OK);
        run <= 4'h2;
        step(4);
        `CHK(pout[0], 1'b1)
        run <= 4'h0;
        num <= 8'h5A;
        pulse();
        `CHK(seen, 4'b1001)
        `CHK(got, 8'h5A)
        stp <= 1'b1;
        step(8);
        `CHK(halt, 4'b1001)
        `CHK(pout[6], 1'b1)
        pulse();
        `CHK(n_l, 0)
        stp <= 1'b0;
        step(8);
        `CHK(halt, 4'h0)
        wr(8'h00, 32'h0F, RESP_OK);
        step(8);
        `CHK(halt, 4'b1001)
        stp <= 1'b1;
        step(8);
        `CHK(halt, 4'h0)
        stp <= 1'b0;
        wr(8'h00, 32'h2B, RESP_OK);
        step(8);
        `CHK(pout[6], 1'b1)
        wr(8'h00, 32'h0B, RESP_OK);
        key <= KEY_TEACH;
        step(8);
        `CHK(pout[3], 1'b0)
        key <= KEY_REMOTE;
        wr(8'h24, 32'hFFFF, RESP_OK);
        step(8);
        pulse();
        `CHK(n_l, 0)
        `CHK(pen[0], 1'b0)
        give_verdict();
    end
endmodule : dioc_bench
`default_nettype wire

// File: bench/dioc_plc.sv
// sequencer model driving the dedicated inputs
`timescale 1ns/1ps
`default_nettype none
module dioc_plc (
    input  wire logic        clk,
    input  wire logic        remote,
    input  wire logic        want,
    input  wire logic        go,
    input  wire logic        stop,
    input  wire logic [7:0]  num,
    output logic      [15:0] pio
);
    // no rights request or start until remote mode is reported; stop passes always
    // number stands in the same cycle as the start edge
    always @(posedge clk) begin
        pio <= {num, 2'h0, want & remote, 1'b0, go & remote, 2'h0, stop};
    end
endmodule : dioc_plc
`default_nettype wire

// File: src/dioc_pkg.sv
// constants for the dedicated parallel i/o control block
package dioc_pkg;
    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int PIO_W   = 16;
    localparam int SLOTS   = 4;
    localparam int NFUNC   = 8;
    localparam int NUM_LSB = 8;
    localparam int NUM_W   = 8;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SLOT   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MAP0   = 8'h10;
    localparam logic [7:0] OFS_MAPN   = 8'h2C;
    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    localparam int CTRL_READY   = 0;
    localparam int CTRL_DIRECT  = 1;
    localparam int CTRL_STOPNC  = 2;
    localparam int CTRL_MULTI   = 3;
    localparam int CTRL_OTHRGT  = 4;
    localparam int CTRL_OTHSTOP = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;
    // ------------------------------------------------------------------
    // function map index: byte 0 input bit, byte 1 output bit
    // ------------------------------------------------------------------
    localparam int F_READY  = 0;
    localparam int F_REMOTE = 1;
    localparam int F_TEACH  = 2;
    localparam int F_PANEL  = 3;
    localparam int F_RIGHTS = 4;
    localparam int F_START  = 5;
    localparam int F_STOP   = 6;
    localparam int F_STPSTS = 7;
    localparam logic [7:0] BIT_OFF  = 8'hFF;
    localparam logic [7:0] STOP_BIT = 8'h00;
    localparam logic [15:0] MAP_RST [NFUNC] = '{
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
        16'h0305, 16'h0003, 16'hFF00, 16'hFFFF};
    // ------------------------------------------------------------------
    // slot start conditions and selector positions
    // ------------------------------------------------------------------
    localparam logic [1:0] COND_START  = 2'h0;
    localparam logic [1:0] COND_ALWAYS = 2'h1;
    localparam logic [1:0] COND_ERROR  = 2'h2;
    localparam logic [7:0] SLOT_RST    = 8'h00;
    localparam logic [1:0] KEY_TEACH   = 2'h0;
    localparam logic [1:0] KEY_PANEL   = 2'h1;
    localparam logic [1:0] KEY_REMOTE  = 2'h2;
    localparam logic [1:0] RESP_OK     = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {DIOC_W_IDLE, DIOC_W_RESP} dioc_wstate_t;
endpackage : dioc_pkg

// File: src/dioc_top.sv
// dedicated parallel i/o control with axi4-lite configuration slave
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dioc_top import dioc_pkg::*; (
    input  wire logic                 SYS_CLK,
    input  wire logic                 SYS_RST,
    input  wire logic [PIO_W-1:0]     PIO_IN,
    input  wire logic [1:0]           KEY_MODE,
    input  wire logic [SLOTS-1:0]     SLOT_RUN,
    input  wire logic [SLOTS-1:0]     SLOT_PAUSE,
    output logic      [PIO_W-1:0]     PIO_OUT,
    output logic      [PIO_W-1:0]     PIO_OUT_EN,
    output logic      [SLOTS-1:0]     SLOT_LAUNCH,
    output logic      [SLOTS-1:0]     SLOT_HALT,
    output logic                      PROG_LOAD,
    output logic      [NUM_W-1:0]     PROG_NUM,
    input  wire logic [7:0]           S_AXI_AWADDR,
    input  wire logic                 S_AXI_AWVALID,
    output logic                      S_AXI_AWREADY,
    input  wire logic [31:0]          S_AXI_WDATA,
    input  wire logic [3:0]           S_AXI_WSTRB,
    input  wire logic                 S_AXI_WVALID,
    output logic                      S_AXI_WREADY,
    output logic [1:0]                S_AXI_BRESP,
    output logic                      S_AXI_BVALID,
    input  wire logic                 S_AXI_BREADY,
    input  wire logic [7:0]           S_AXI_ARADDR,
    input  wire logic                 S_AXI_ARVALID,
    output logic                      S_AXI_ARREADY,
    output logic [31:0]               S_AXI_RDATA,
    output logic [1:0]                S_AXI_RRESP,
    output logic                      S_AXI_RVALID,
    input  wire logic                 S_AXI_RREADY
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic pick(input logic [7:0] num,
                                  input logic [PIO_W-1:0] vec);
        pick = 1'b0;
        if (num != BIT_OFF && num < 8'(PIO_W))
            pick = vec[num[3:0]];
    endfunction : pick

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                merge[8*b +: 8] = nw[8*b +: 8];
    endfunction : merge

    function automatic logic map_hit(input logic [7:0] a);
        map_hit = (a >= OFS_MAP0) && (a <= OFS_MAPN) && (a[1:0] == 2'h0);
    endfunction : map_hit

    // map words start at the map base, not at address zero
    function automatic logic [2:0] map_idx(input logic [7:0] a);
        logic [7:0] rel;
        rel     = a - OFS_MAP0;
        map_idx = rel[4:2];
    endfunction : map_idx

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [PIO_W-1:0] in_meta_reg, in_sync_reg;
    logic [1:0]       key_meta_reg, key_sync_reg;
    logic             start_prev_reg;

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            in_meta_reg  <= '0;
            in_sync_reg  <= '0;
            key_meta_reg <= KEY_TEACH;
            key_sync_reg <= KEY_TEACH;
        end else begin
            in_meta_reg  <= PIO_IN;
            in_sync_reg  <= in_meta_reg;
            key_meta_reg <= KEY_MODE;
            key_sync_reg <= key_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [5:0]  ctrl_reg;
    logic [7:0]  slot_reg;
    logic [15:0] map_reg [NFUNC];

    // ------------------------------------------------------------------
    // mode decode and dedicated inputs
    // ------------------------------------------------------------------
    logic             remote_now, teach_now, panel_now;
    logic             rights_in, start_in, stop_raw, stop_act;
    logic             start_edge, other_stop;
    logic             rights_reg;
    logic [SLOTS-1:0] eligible, run_eff, pause_eff;

    assign remote_now = key_sync_reg == KEY_REMOTE;
    assign teach_now  = key_sync_reg == KEY_TEACH;
    assign panel_now  = key_sync_reg == KEY_PANEL;
    // disabled input reads as inactive
    assign rights_in  = pick(map_reg[F_RIGHTS][7:0], in_sync_reg);
    assign start_in   = pick(map_reg[F_START][7:0], in_sync_reg);
    // stop stays on bit 0 whatever the map byte says
    assign stop_raw   = pick(STOP_BIT, in_sync_reg);
    assign stop_act   = remote_now
                        && (stop_raw ^ ctrl_reg[CTRL_STOPNC]);
    assign other_stop = ctrl_reg[CTRL_OTHSTOP];
    assign start_edge = start_in && !start_prev_reg;

    always_comb begin
        for (int s = 0; s < SLOTS; s++) begin
            eligible[s] = slot_reg[2*s +: 2] != COND_ALWAYS
                          && slot_reg[2*s +: 2] != COND_ERROR;
            if (!ctrl_reg[CTRL_MULTI] && s != 0)
                eligible[s] = 1'b0;
        end
    end
    // single task mode only watches slot 0
    assign run_eff   = ctrl_reg[CTRL_MULTI] ? SLOT_RUN : SLOT_RUN & 4'h1;
    assign pause_eff = ctrl_reg[CTRL_MULTI] ? SLOT_PAUSE : SLOT_PAUSE & 4'h1;

    // ------------------------------------------------------------------
    // rights, start, stop
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rights_reg     <= 1'b0;
            start_prev_reg <= 1'b0;
        end else begin
            rights_reg     <= rights_in && remote_now
                              && !ctrl_reg[CTRL_OTHRGT];
            start_prev_reg <= start_in;
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            SLOT_LAUNCH <= '0;
            SLOT_HALT   <= '0;
            PROG_LOAD   <= 1'b0;
            PROG_NUM    <= '0;
        end else begin
            // a held stop blocks launches; stop wins over start
            SLOT_HALT   <= stop_act ? eligible : '0;
            SLOT_LAUNCH <= '0;
            PROG_LOAD   <= 1'b0;
            if (start_edge && rights_reg && remote_now && !stop_act) begin
                SLOT_LAUNCH <= eligible;
                if (ctrl_reg[CTRL_DIRECT]) begin
                    PROG_LOAD <= 1'b1;
                    PROG_NUM  <= in_sync_reg[NUM_LSB +: NUM_W];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // status outputs onto the parallel port
    // ------------------------------------------------------------------
    logic [NFUNC-1:0] fval;
    logic [PIO_W-1:0] out_next, en_next;

    always_comb begin
        fval[F_READY]  = ctrl_reg[CTRL_READY];
        fval[F_REMOTE] = remote_now;
        fval[F_TEACH]  = teach_now;
        fval[F_PANEL]  = panel_now;
        fval[F_RIGHTS] = rights_reg;
        fval[F_START]  = |run_eff;
        fval[F_STOP]   = !(|run_eff) && (|pause_eff);
        fval[F_STPSTS] = stop_act || other_stop;
        out_next = '0;
        en_next  = '0;
        for (int f = 0; f < NFUNC; f++) begin
            if (map_reg[f][15:8] != BIT_OFF
                && map_reg[f][15:8] < 8'(PIO_W)) begin
                en_next[map_reg[f][11:8]]  = 1'b1;
                out_next[map_reg[f][11:8]] = fval[f];
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PIO_OUT    <= '0;
            PIO_OUT_EN <= '0;
        end else begin
            PIO_OUT    <= out_next;
            PIO_OUT_EN <= en_next;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    logic         aw_have_reg, w_have_reg;
    logic [7:0]   aw_addr_reg;
    logic [31:0]  w_data_reg;
    logic [3:0]   w_strb_reg;
    logic         wr_go, wr_ok;
    logic [31:0]  map_word, ctrl_word, slot_word, map_new;

    assign wr_go = aw_have_reg && w_have_reg && !S_AXI_BVALID;
    assign wr_ok = aw_addr_reg == OFS_CTRL || aw_addr_reg == OFS_SLOT
                   || map_hit(aw_addr_reg);
    assign map_word  = {16'h0000, map_reg[map_idx(aw_addr_reg)]};
    assign ctrl_word = merge({26'h0, ctrl_reg}, w_data_reg, w_strb_reg);
    assign slot_word = merge({24'h0, slot_reg}, w_data_reg, w_strb_reg);
    assign map_new   = merge(map_word, w_data_reg, w_strb_reg);

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= '0;
            w_strb_reg    <= '0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OK;
        end else begin
            S_AXI_AWREADY <= !aw_have_reg && !S_AXI_AWREADY;
            S_AXI_WREADY  <= !w_have_reg && !S_AXI_WREADY;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_reg   <= 1'b1;
                aw_addr_reg   <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_reg   <= 1'b1;
                w_data_reg   <= S_AXI_WDATA;
                w_strb_reg   <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_go) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_ok ? RESP_OK : RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_reg <= CTRL_RST;
            slot_reg <= SLOT_RST;
            for (int f = 0; f < NFUNC; f++)
                map_reg[f] <= MAP_RST[f];
        end else if (wr_go) begin
            if (aw_addr_reg == OFS_CTRL)
                ctrl_reg <= ctrl_word[5:0];
            if (aw_addr_reg == OFS_SLOT)
                slot_reg <= slot_word[7:0];
            if (map_hit(aw_addr_reg))
                map_reg[map_idx(aw_addr_reg)] <= map_new[15:0];
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    logic [31:0] rd_word;
    logic        rd_ok;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (S_AXI_ARADDR == OFS_CTRL)
            rd_word[5:0] = ctrl_reg;
        else if (S_AXI_ARADDR == OFS_SLOT)
            rd_word[7:0] = slot_reg;
        else if (S_AXI_ARADDR == OFS_STATUS)
            rd_word[15:0] = {in_sync_reg[7:0], fval};
        else if (map_hit(S_AXI_ARADDR))
            rd_word[15:0] = map_reg[map_idx(S_AXI_ARADDR)];
        else
            rd_ok = 1'b0;
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= '0;
            S_AXI_RRESP   <= RESP_OK;
        end else begin
            // one read in flight; ready only pulses while idle
            S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID  <= 1'b1;
                S_AXI_RDATA   <= rd_word;
                S_AXI_RRESP   <= rd_ok ? RESP_OK : RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_rights_cause;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        rights_reg |-> $past(rights_in && remote_now
                             && !ctrl_reg[CTRL_OTHRGT]);
    endproperty
    a_rights_cause: assert property (p_rights_cause)
        else $error("rights held without cause");

    property p_launch_remote;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (SLOT_LAUNCH != '0) |-> $past(remote_now && rights_reg && start_edge);
    endproperty
    a_launch_remote: assert property (p_launch_remote)
        else $error("launch outside remote with rights");

    property p_launch_once;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (SLOT_LAUNCH != '0) |=> (SLOT_LAUNCH == '0);
    endproperty
    a_launch_once: assert property (p_launch_once)
        else $error("launch lasted more than one cycle");

    property p_launch_skip;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (SLOT_LAUNCH & ~$past(eligible)) == '0;
    endproperty
    a_launch_skip: assert property (p_launch_skip)
        else $error("excluded slot launched");

    property p_halt_stop;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        $rose(stop_act) |=> (SLOT_HALT == $past(eligible));
    endproperty
    a_halt_stop: assert property (p_halt_stop)
        else $error("stop did not halt slots");

    property p_operating;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (map_reg[F_START][15:8] == 8'h00 && $stable(map_reg[F_START]))
            |-> (PIO_OUT[0] == $past(|run_eff));
    endproperty
    a_operating: assert property (p_operating)
        else $error("operating output wrong");

    property p_paused;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (map_reg[F_STOP][15:8] < 8'(PIO_W) && $stable(map_reg[F_STOP]))
            |-> (pick(map_reg[F_STOP][15:8], PIO_OUT)
                 == $past(!(|run_eff) && (|pause_eff)));
    endproperty
    a_paused: assert property (p_paused)
        else $error("paused while running");

    property p_load_num;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        PROG_LOAD |-> (PROG_NUM == $past(in_sync_reg[NUM_LSB +: NUM_W])
                       && SLOT_LAUNCH != '0);
    endproperty
    a_load_num: assert property (p_load_num)
        else $error("program number not from data inputs");

    property p_disabled_start;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        ($past(map_reg[F_START][7:0]) == BIT_OFF) |-> (SLOT_LAUNCH == '0);
    endproperty
    a_disabled_start: assert property (p_disabled_start)
        else $error("disabled start input launched slots");

    property p_stop_status;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        ($past(stop_act || other_stop) && $stable(map_reg[F_STPSTS])
         && map_reg[F_STPSTS][15:8] < 8'(PIO_W))
            |-> pick(map_reg[F_STPSTS][15:8], PIO_OUT);
    endproperty
    a_stop_status: assert property (p_stop_status)
        else $error("stop status misses other source");

    c_launch: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        SLOT_LAUNCH != '0);
    c_halt: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        SLOT_HALT != '0);
    c_rights: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        $rose(rights_reg));
    c_paused: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        fval[F_STOP]);
endmodule : dioc_top
`default_nettype wire
